// >>> hw/sdtg_regs.svh
`ifndef SDTG_REGS_SVH
`define SDTG_REGS_SVH

// register indices, byte address is index times four
`define SDTG_R_CTRL 3'h0
`define SDTG_R_DIV 3'h1
`define SDTG_R_EDGE 3'h2
`define SDTG_R_HLINE 3'h3
`define SDTG_R_HSYNC 3'h4
`define SDTG_R_HACT 3'h5
`define SDTG_R_VFRM 3'h6
`define SDTG_R_STAT 3'h7
`define SDTG_R_LAST_RW 3'h6

// field positions
`define SDTG_F_EN 0
`define SDTG_F_TV 1
`define SDTG_F_FRAC 3:0
`define SDTG_F_INT 15:4
`define SDTG_F_RATIO 7:0
`define SDTG_F_RISE 15:8
`define SDTG_F_FALL 23:16
`define SDTG_F_LO 11:0
`define SDTG_F_HI 27:16
`define SDTG_F_EVEN 0
`define SDTG_F_UNDER 1
`define SDTG_F_RATE 2
`define SDTG_F_ADDR_HI 7:5

// reset values
`define SDTG_RST_CTRL 32'h0000_0000
`define SDTG_RST_DIV 32'h0000_0010
`define SDTG_RST_EDGE 32'h0002_0101
`define SDTG_RST_HLINE 32'h0000_0100
`define SDTG_RST_HSYNC 32'h0008_0000
`define SDTG_RST_HACT 32'h00c0_0020
`define SDTG_RST_VFRM 32'h0002_0100

// bus answers and small constants
`define SDTG_RESP_OKAY 2'h0
`define SDTG_RESP_SLVERR 2'h2
`define SDTG_LEN_MIN 12'h001

// base clock and tv link rate in hz, tolerance in percent
`define SDTG_CORE_HZ 64'h0000_0000_017d_7840
`define SDTG_TV_HZ 64'h0000_0000_019b_fcc0
`define SDTG_TV_TOL 64'h0000_0000_0000_000a
`define SDTG_PCT 64'h0000_0000_0000_0064
`define SDTG_FRAC_ONE 64'h0000_0000_0000_0010

`endif

// >>> hw/sdtg_pkg.sv
package sdtg_pkg;

   // signals of the display link, updated together
   typedef struct packed {
      logic line_n;
      logic frame_n;
      logic valid;
      logic [7:0] data;
   } sdtg_link_t;

   // field being scanned
   typedef enum logic {SDTG_FIELD_ODD, SDTG_FIELD_EVEN} sdtg_field_t;

endpackage

// >>> hw/sdtg_top.sv
// How it works
// - the pixel clock period is a divider in base clocks with 1/16 steps.
// - integer ratios give equal periods, fractional ones alternate floor and floor plus one.
// - each sync counter makes a pulse from its programmed offset, period and width; frame sync has no offset field and starts at the field start.
// - line sync pulses repeat exactly one programmed line length apart.
// - clock edges sit on a half base clock grid, pixel data on a full base clock grid.
// - the clock fall sits at half a base clock times ceil(2*fall/ratio).
// - the clock rise sits at half a base clock times ceil(2*rise/ratio).
// - the clock is low from rise to fall position and high otherwise.
// - the tv link carries one 8-bit component per pixel clock.
// - the tv link runs near 27 MHz within ten percent.
// - line and frame sync are active low, data valid is active high.
// - in tv mode line sync falls at each row and stays low one pixel clock.
// - frame sync falls at each field and stays low at least one pixel clock.
// - odd field sync edges coincide with line sync, even field ones do not.
// - data moves only while line sync is high.
// - frame sync spans at least one line sync pulse.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "sdtg_regs.svh"
module sdtg_top #(
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RSTN,
   // axi4-lite write channels
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read channels
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // component stream in
   input wire logic [7:0] PIX_DATA,
   input wire logic PIX_VALID,
   output logic PIX_READY,
   // display link
   output logic DISP_CLK_FIRST,
   output logic DISP_CLK_SECOND,
   output var sdtg_pkg::sdtg_link_t LINK
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [63:0] HZ16 = `SDTG_CORE_HZ * `SDTG_FRAC_ONE * `SDTG_PCT;
   localparam logic [63:0] TV_LO = `SDTG_TV_HZ * (`SDTG_PCT - `SDTG_TV_TOL);
   localparam logic [63:0] TV_HI = `SDTG_TV_HZ * (`SDTG_PCT + `SDTG_TV_TOL);

   logic [31:0] cfg [0:6];
   logic aw_got, w_got, wr_go, under;
   logic [2:0] aw_idx;
   logic aw_bad;
   logic [31:0] wdat;
   logic [3:0] wstb;
   logic [11:0] c, len_cur, int_eff, next_len, pix, line, next_pix, next_line;
   logic [3:0] acc;
   logic [4:0] acc_sum;
   logic tick, en, tv, odd_start, even_start, hs_act, vs_act, act, pop, push;
   logic rate_ok;
   logic [23:0] vcnt, next_vcnt;
   sdtg_pkg::sdtg_field_t field;
   logic [7:0] mem [0:DEPTH-1];
   logic [PW-1:0] wp, rp;
   logic [CW-1:0] count, next_count;

   assign en = cfg[`SDTG_R_CTRL][`SDTG_F_EN];
   assign tv = cfg[`SDTG_R_CTRL][`SDTG_F_TV];

   // write address and data are taken in either order, answered together
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         AWREADY <= 1'b1;
         WREADY <= 1'b1;
         BVALID <= 1'b0;
         BRESP <= `SDTG_RESP_OKAY;
         aw_idx <= '0;
         aw_bad <= 1'b0;
         wdat <= '0;
         wstb <= '0;
      end
      else
      begin
         if (AWVALID && AWREADY)
         begin
            aw_got <= 1'b1;
            AWREADY <= 1'b0;
            aw_idx <= AWADDR[4:2];
            aw_bad <= (AWADDR[`SDTG_F_ADDR_HI] != '0);
         end
         if (WVALID && WREADY)
         begin
            w_got <= 1'b1;
            WREADY <= 1'b0;
            wdat <= WDATA;
            wstb <= WSTRB;
         end
         if (wr_go)
         begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= aw_bad ? `SDTG_RESP_SLVERR : `SDTG_RESP_OKAY;
         end
         if (BVALID && BREADY)
         begin
            BVALID <= 1'b0;
            AWREADY <= 1'b1;
            WREADY <= 1'b1;
         end
      end
   end
   assign wr_go = aw_got && w_got && !BVALID;

   // configuration registers with byte strobes
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         cfg[`SDTG_R_CTRL] <= `SDTG_RST_CTRL;
         cfg[`SDTG_R_DIV] <= `SDTG_RST_DIV;
         cfg[`SDTG_R_EDGE] <= `SDTG_RST_EDGE;
         cfg[`SDTG_R_HLINE] <= `SDTG_RST_HLINE;
         cfg[`SDTG_R_HSYNC] <= `SDTG_RST_HSYNC;
         cfg[`SDTG_R_HACT] <= `SDTG_RST_HACT;
         cfg[`SDTG_R_VFRM] <= `SDTG_RST_VFRM;
      end
      else if (wr_go && !aw_bad && aw_idx <= `SDTG_R_LAST_RW)
      begin
         for (int b = 0; b < 4; b++)
         begin
            if (wstb[b])
               cfg[aw_idx][b*8 +: 8] <= wdat[b*8 +: 8];
         end
      end
   end

   // status: underrun is sticky, cleared by writing one, a new one wins
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
         under <= 1'b0;
      else if (tick && act && count == '0)
         under <= 1'b1;
      else if (wr_go && !aw_bad && aw_idx == `SDTG_R_STAT
               && wstb[0] && wdat[`SDTG_F_UNDER])
         under <= 1'b0;
   end

   // the tv link needs the pixel clock within tolerance of 27 MHz
   assign rate_ok = (64'(cfg[`SDTG_R_DIV][15:0]) * TV_LO <= HZ16)
                    && (64'(cfg[`SDTG_R_DIV][15:0]) * TV_HI >= HZ16);

   // read channel, one outstanding read
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         ARREADY <= 1'b1;
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= `SDTG_RESP_OKAY;
      end
      else if (ARVALID && ARREADY)
      begin
         ARREADY <= 1'b0;
         RVALID <= 1'b1;
         RRESP <= `SDTG_RESP_OKAY;
         if (ARADDR[`SDTG_F_ADDR_HI] != '0)
         begin
            RDATA <= '0;
            RRESP <= `SDTG_RESP_SLVERR;
         end
         else if (ARADDR[4:2] == `SDTG_R_STAT)
            RDATA <= {4'h0, line, 13'h0000, rate_ok, under, field};
         else
            RDATA <= cfg[ARADDR[4:2]];
      end
      else if (RVALID && RREADY)
      begin
         RVALID <= 1'b0;
         ARREADY <= 1'b1;
      end
   end

   // period length: integer part plus one when the fraction overflows
   always_comb
   begin
      acc_sum = {1'b0, acc} + {1'b0, cfg[`SDTG_R_DIV][`SDTG_F_FRAC]};
      int_eff = (cfg[`SDTG_R_DIV][`SDTG_F_INT] == '0) ? `SDTG_LEN_MIN
                : cfg[`SDTG_R_DIV][`SDTG_F_INT];
      next_len = int_eff + 12'(acc_sum[4]);
   end
   assign tick = en && (c == len_cur - `SDTG_LEN_MIN);

   // base clock counter inside one pixel clock period
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN || !en)
      begin
         c <= '0;
         acc <= '0;
         len_cur <= `SDTG_LEN_MIN;
      end
      else if (tick)
      begin
         c <= '0;
         acc <= acc_sum[3:0];
         len_cur <= next_len;
      end
      else
         c <= c + `SDTG_LEN_MIN;
   end

   // clock level at a half step: low between rise and fall positions
   function automatic logic clk_level(input logic [12:0] h,
                                      input logic [31:0] e);
      logic [20:0] p;
      p = 21'(h) * 21'(e[`SDTG_F_RATIO]);
      clk_level = !((p >= 21'({e[`SDTG_F_RISE], 1'b0}))
                    && (p < 21'({e[`SDTG_F_FALL], 1'b0})));
   endfunction

   // two half-step phases per base clock
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN || !en)
      begin
         DISP_CLK_FIRST <= 1'b1;
         DISP_CLK_SECOND <= 1'b1;
      end
      else
      begin
         DISP_CLK_FIRST <= clk_level({c, 1'b0}, cfg[`SDTG_R_EDGE]);
         DISP_CLK_SECOND <= clk_level({c, 1'b1}, cfg[`SDTG_R_EDGE]);
      end
   end

   // next positions and sync levels at the coming pixel clock
   always_comb
   begin
      next_pix = pix + `SDTG_LEN_MIN;
      next_line = line;
      if (pix >= cfg[`SDTG_R_HLINE][`SDTG_F_LO] - `SDTG_LEN_MIN)
      begin
         next_pix = '0;
         next_line = line + `SDTG_LEN_MIN;
         if (line >= cfg[`SDTG_R_VFRM][`SDTG_F_LO] - `SDTG_LEN_MIN)
            next_line = '0;
      end
      odd_start = (next_pix == '0) && (next_line == '0);
      even_start = tv && (next_line == cfg[`SDTG_R_VFRM][`SDTG_F_LO] >> 1)
                   && (next_pix == cfg[`SDTG_R_HLINE][`SDTG_F_LO] >> 1);
      next_vcnt = (odd_start || even_start) ? '0
                  : (vcnt == '1) ? vcnt : vcnt + 24'h00_0001;
      if (tv)
         hs_act = (next_pix == '0);
      else
         hs_act = (next_pix >= cfg[`SDTG_R_HSYNC][`SDTG_F_LO])
                  && (13'(next_pix) < 13'(cfg[`SDTG_R_HSYNC][`SDTG_F_LO])
                      + 13'(cfg[`SDTG_R_HSYNC][`SDTG_F_HI]));
      vs_act = (next_vcnt == '0)
               || (next_vcnt < 24'(cfg[`SDTG_R_VFRM][`SDTG_F_HI])
                   * 24'(cfg[`SDTG_R_HLINE][`SDTG_F_LO]));
      act = (next_pix >= cfg[`SDTG_R_HACT][`SDTG_F_LO])
            && (13'(next_pix) < 13'(cfg[`SDTG_R_HACT][`SDTG_F_LO])
                + 13'(cfg[`SDTG_R_HACT][`SDTG_F_HI]))
            && !hs_act;
   end
   assign pop = tick && act && (count != '0);

   // pixel, line and field counters step once per pixel clock
   // they restart when disabled, so a new run begins at line 0 of an odd field
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN || !en)
      begin
         pix <= '0;
         line <= '0;
         vcnt <= '1;
         field <= sdtg_pkg::SDTG_FIELD_ODD;
      end
      else if (tick)
      begin
         pix <= next_pix;
         line <= next_line;
         vcnt <= next_vcnt;
         if (odd_start)
            field <= sdtg_pkg::SDTG_FIELD_ODD;
         else if (even_start)
            field <= sdtg_pkg::SDTG_FIELD_EVEN;
      end
   end

   // link outputs change on the pixel clock grid only
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN || !en)
      begin
         LINK.line_n <= 1'b1;
         LINK.frame_n <= 1'b1;
         LINK.valid <= 1'b0;
         LINK.data <= '0;
      end
      else if (tick)
      begin
         LINK.line_n <= !hs_act;
         LINK.frame_n <= !vs_act;
         LINK.valid <= pop;
         if (pop)
            LINK.data <= mem[rp];
      end
   end

   // two-entry buffer in front of the link
   assign push = PIX_VALID && PIX_READY;
   assign next_count = count + CW'(push) - CW'(pop);
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN)
      begin
         wp <= '0;
         rp <= '0;
         count <= '0;
         PIX_READY <= 1'b0;
      end
      else
      begin
         count <= next_count;
         PIX_READY <= (next_count < CW'(DEPTH));
         if (push)
         begin
            mem[wp] <= PIX_DATA;
            wp <= (wp == PW'(DEPTH - 1)) ? '0 : wp + PW'(1);
         end
         if (pop)
            rp <= (rp == PW'(DEPTH - 1)) ? '0 : rp + PW'(1);
      end
   end

   // helpers for checks: pixel clocks between line sync falls
   logic [11:0] ls_cnt;
   logic ls_seen, tick_seen;
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN || !en)
      begin
         ls_cnt <= '0;
         ls_seen <= 1'b0;
         tick_seen <= 1'b0;
      end
      else if (tick)
      begin
         tick_seen <= 1'b1;
         ls_cnt <= (LINK.line_n && hs_act) ? `SDTG_LEN_MIN
                   : ls_cnt + `SDTG_LEN_MIN;
         if (LINK.line_n && hs_act)
            ls_seen <= 1'b1;
      end
   end

   period_len_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (tick && tick_seen) |-> (len_cur == int_eff)
         || (len_cur == int_eff + `SDTG_LEN_MIN
             && cfg[`SDTG_R_DIV][`SDTG_F_FRAC] != '0))
      else $error("pixel clock period off its divider");
   line_space_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (tick && ls_seen && LINK.line_n && hs_act)
         |-> (ls_cnt == cfg[`SDTG_R_HLINE][`SDTG_F_LO]))
      else $error("line sync spacing differs from line length");
   tv_line_one_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (tick && tv && !LINK.line_n) |=> LINK.line_n)
      else $error("tv line sync low longer than one pixel clock");
   odd_edges_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      ($fell(LINK.frame_n) && field == sdtg_pkg::SDTG_FIELD_ODD && tv)
         |-> $fell(LINK.line_n))
      else $error("odd field sync edges do not coincide");
   even_edges_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      ($fell(LINK.frame_n) && field == sdtg_pkg::SDTG_FIELD_EVEN)
         |-> !$fell(LINK.line_n))
      else $error("even field sync edges coincide");
   data_hsync_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      LINK.valid |-> LINK.line_n)
      else $error("data valid while line sync low");
   // helper for checks: a pixel tick seen while frame sync is low
   logic fr_tick;
   always_ff @(posedge CORE_CLK)
   begin
      if (!RSTN || !en || LINK.frame_n)
         fr_tick <= 1'b0;
      else if (tick)
         fr_tick <= 1'b1;
   end

   frame_low_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      ($rose(LINK.frame_n) && en) |-> fr_tick)
      else $error("frame sync shorter than one pixel clock");
   clk_low_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (en && c == '0 && cfg[`SDTG_R_EDGE][`SDTG_F_RISE] == '0
       && cfg[`SDTG_R_EDGE][`SDTG_F_FALL] != '0
       && cfg[`SDTG_R_EDGE][`SDTG_F_RATIO] != '0) |=> !DISP_CLK_FIRST)
      else $error("pixel clock not low at a zero rise position");
   buf_full_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      (count == CW'(DEPTH)) |-> !PIX_READY ##1 !(count > CW'(DEPTH)))
      else $error("buffer accepts a word while full");
endmodule
`default_nettype wire

// >>> tb/sdtg_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
// encoder side: times line sync, counts frame starts and stray data
module sdtg_panel_model (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // display link
   input wire sdtg_pkg::sdtg_link_t link,
   // observations
   output logic strobe,
   output logic [15:0] gap,
   output logic [15:0] low,
   output logic [15:0] co,
   output logic [15:0] nc,
   output logic [15:0] bad
);
   logic pl;
   logic pf;
   logic [15:0] run;
   logic [15:0] lrun;
   // sample the link at every base clock
   always_ff @(posedge clk)
   begin
      pl <= link.line_n;
      pf <= link.frame_n;
      run <= run + 16'h1;
      strobe <= 1'b0;
      if (pl && !link.line_n)
      begin
         strobe <= 1'b1;
         gap <= run;
         run <= 16'h1;
      end
      if (!link.line_n)
         lrun <= lrun + 16'h1;
      else if (lrun != 16'h0)
      begin
         low <= lrun;
         lrun <= 16'h0;
      end
      if (pf && !link.frame_n && pl && !link.line_n)
         co <= co + 16'h1;
      if (pf && !link.frame_n && !(pl && !link.line_n))
         nc <= nc + 16'h1;
      if (link.valid && !link.line_n)
         bad <= bad + 16'h1;
      if (!rstn)
      begin
         pl <= 1'b1;
         pf <= 1'b1;
         run <= 16'h0;
         lrun <= 16'h0;
         co <= 16'h0;
         nc <= 16'h0;
         bad <= 16'h0;
      end
   end
endmodule
`default_nettype wire

// >>> tb/sync_display_timing_gen_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdtg_regs.svh"
module sync_display_timing_gen_tb;
   logic clk, rstn, awv, wv, bready, arv, rready, pv, feed, dchk;
   logic [7:0] awaddr, araddr, pd;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic awready, wready, bvalid, arready, rvalid, pready, strobe;
   logic dcf, dcs;
   logic [15:0] gap, low, co, nc, bad, exp_gap, exp_low;
   sdtg_pkg::sdtg_link_t link;
   logic [1:0] bq[$];
   logic [65:0] rq[$];
   logic [65:0] re;
   logic [7:0] pq[$];
   logic [31:0] rst[7] = '{`SDTG_RST_CTRL, `SDTG_RST_DIV, `SDTG_RST_EDGE,
      `SDTG_RST_HLINE, `SDTG_RST_HSYNC, `SDTG_RST_HACT, `SDTG_RST_VFRM};
   int error_cnt = 0, n_compared = 0, skip = 3, cyc = 0;

   sdtg_top u_dut (.CORE_CLK(clk), .RSTN(rstn), .AWADDR(awaddr),
      .AWVALID(awv), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf),
      .WVALID(wv), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arv), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .PIX_DATA(pd), .PIX_VALID(pv), .PIX_READY(pready),
      .DISP_CLK_FIRST(dcf), .DISP_CLK_SECOND(dcs), .LINK(link));
   sdtg_panel_model u_pan (.clk(clk), .rstn(rstn), .link(link),
      .strobe(strobe), .gap(gap), .low(low), .co(co), .nc(nc), .bad(bad));

   // base clock
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      bq.push_back(r);
      awaddr <= a;
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      fork
         begin
            do @(posedge clk); while (awready !== 1'b1);
            awv <= 1'b0;
         end
         begin
            do @(posedge clk); while (wready !== 1'b1);
            wv <= 1'b0;
         end
      join
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic axr(input logic [7:0] a, input logic [31:0] m, d,
      input logic [1:0] r);
      rq.push_back({r, m, d & m});
      araddr <= a;
      arv <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arv <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      @(posedge clk);
   endtask

   // bus answers against the noted expectations
   always @(posedge clk)
   begin
      if (bvalid && bready)
         chk("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
      if (rvalid && rready)
      begin
         re = rq.pop_front();
         chk("rresp", {30'h0, re[65:64]}, {30'h0, rresp});
         chk("rdata", re[31:0], rdata & re[63:32]);
      end
   end

   // component source, stalled by the buffer
   always @(posedge clk)
   begin
      if (pv && pready)
         pq.push_back(pd);
      if (feed && (!pv || pready))
      begin
         pv <= 1'b1;
         pd <= 8'($urandom);
      end
      else if (pv && pready)
         pv <= 1'b0;
   end

   // link data and line timing
   always @(posedge clk)
   begin
      if (dchk && link.valid === 1'b1)
      begin
         if (pq.size() == 0)
            chk("pix_extra", 32'h0, 32'h1);
         else
            chk("pix_data", {24'h0, pq.pop_front()}, {24'h0, link.data});
      end
      if (strobe && skip > 0)
         skip--;
      else if (strobe)
      begin
         chk("line_gap", {16'h0, exp_gap}, {16'h0, gap});
         if (exp_low != 16'h0)
            chk("line_low", {16'h0, exp_low}, {16'h0, low});
      end
   end

   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         error_cnt++;
         close_out();
      end
   end

   // main sequence
   initial
   begin
      {awv, wv, bready, arv, rready, pv, feed, dchk} = 8'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      pd = 8'h00;
      rstn = 1'b0;
      exp_gap = 16'h10;
      exp_low = 16'h1;
      void'($urandom(41720));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      axw(8'h20, 32'h0000_0003, `SDTG_RESP_SLVERR);
      axr(8'h24, 32'hffff_ffff, 32'h0, `SDTG_RESP_SLVERR);
      for (int i = 0; i < 7; i++)
         axr(8'(i * 4), 32'hffff_ffff, rst[i], `SDTG_RESP_OKAY);
      axw(8'h04, 32'h0000_0010, `SDTG_RESP_OKAY);
      axw(8'h0c, 32'h0000_0010, `SDTG_RESP_OKAY);
      axw(8'h10, 32'h0001_0000, `SDTG_RESP_OKAY);
      axw(8'h14, 32'h0008_0004, `SDTG_RESP_OKAY);
      axw(8'h18, 32'h0001_0004, `SDTG_RESP_OKAY);
      // ratio 2, rise 0, fall 1: low in the first half step only
      axw(8'h08, 32'h0001_0002, `SDTG_RESP_OKAY);
      feed <= 1'b1;
      dchk <= 1'b1;
      axw(8'h00, 32'h0000_0003, `SDTG_RESP_OKAY);
      repeat (400) @(posedge clk);
      chk("clk_first", 32'h0, {31'h0, dcf});
      chk("clk_second", 32'h1, {31'h0, dcs});
      axr(8'h1c, 32'h0000_0004, 32'h0000_0004, `SDTG_RESP_OKAY);
      feed <= 1'b0;
      repeat (100) @(posedge clk);
      chk("left_in_buffer", 32'h0, pq.size());
      dchk <= 1'b0;
      chk("odd_coincide", 32'h1, {31'h0, co != 16'h0});
      chk("even_apart", 32'h1, {31'h0, nc != 16'h0});
      axr(8'h1c, 32'h0000_0002, 32'h0000_0002, `SDTG_RESP_OKAY);
      axw(8'h00, 32'h0000_0000, `SDTG_RESP_OKAY);
      axw(8'h1c, 32'h0000_0002, `SDTG_RESP_OKAY);
      axr(8'h1c, 32'h0000_0002, 32'h0000_0000, `SDTG_RESP_OKAY);
      skip = 3;
      exp_gap = 16'h18;
      exp_low = 16'h0;
      axw(8'h04, 32'h0000_0018, `SDTG_RESP_OKAY);
      axw(8'h00, 32'h0000_0001, `SDTG_RESP_OKAY);
      repeat (300) @(posedge clk);
      axr(8'h1c, 32'h0000_0004, 32'h0000_0000, `SDTG_RESP_OKAY);
      chk("valid_in_sync", 32'h0, {16'h0, bad});
      close_out();
   end
endmodule
`default_nettype wire
